// ==== hdl/gsr_pkg.sv ====
package gsr_pkg;

  // ----------------------------------------------------------------
  // Address map of the interface slot
  // ----------------------------------------------------------------
  // Full byte addresses of the support registers
  localparam logic [23:0] REG_STATUS_CTRL_ADDR = 24'h47_0003;
  localparam logic [23:0] REG_EXT_STATUS_ADDR  = 24'h47_0005;
  localparam logic [23:0] REG_POLL_STATUS_ADDR = 24'h47_0007;
  localparam logic [23:0] REG_POLL_MASK_ADDR   = 24'h47_0009;
  // The slot is 64 KiB wide; the top byte selects it
  localparam logic [7:0]  SLOT_SELECT          = REG_STATUS_CTRL_ADDR[23:16];
  // Registers repeat every 16 bytes inside the slot
  localparam int          MIRROR_BITS          = 4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int STAT_ONE_BIT     = 7;  // Status: reads constant 1
  localparam int STAT_PEND_BIT    = 6;  // Status: controller irq pending
  localparam int STAT_ZERO_BIT    = 2;  // Status: reads constant 0
  localparam int STAT_DMA_BIT     = 0;  // Status/control: DMA enable
  localparam int EXT_SYSCTL_BIT   = 7;  // Ext: system controller line
  localparam int EXT_CIC_BIT      = 6;  // Ext: in-charge, active low
  localparam int EXT_KEYBOARD_BIT = 2;  // Ext: keyboard level-7 irq
  localparam int EXT_ONE_BIT      = 0;  // Ext: reads constant 1
  localparam int POLL_ENABLE_BIT  = 7;  // Poll status: irq enable
  localparam int POLL_REQUEST_BIT = 6;  // Poll status: irq request

  // ----------------------------------------------------------------
  // Driven-bit masks (undriven bits float on the data bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] STAT_DRIVEN_MASK = 8'hC5;
  localparam logic [7:0] EXT_DRIVEN_MASK  = 8'hC5;
  localparam logic [7:0] ALL_DRIVEN_MASK  = 8'hFF;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic       DMA_ENABLE_RESET = 1'h0;
  localparam logic       POLL_ENABLE_RESET = 1'h0;
  localparam logic [7:0] POLL_MASK_RESET  = 8'h00;

  // ----------------------------------------------------------------
  // Parallel-poll watcher states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    GSR_POLL_OFF    = 3'h1,
    GSR_POLL_SAMPLE = 3'h2,
    GSR_POLL_HELD   = 3'h4
  } gsr_poll_state_e;

endpackage

// ==== hdl/gsr_poll_detect.sv ====
module gsr_poll_detect (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  // Control from the register file
  input  wire logic       enable_i,
  input  wire logic [7:0] mask_i,
  input  wire logic       clear_i,
  // Bus side
  input  wire logic [7:0] data_lines_i,
  input  wire logic       poll_phase_i,
  // Result
  output logic            request_o,
  output logic            sampling_o
);

  // ----------------------------------------------------------------
  // State register and decode
  // ----------------------------------------------------------------
  gsr_pkg::gsr_poll_state_e state;       // Current watcher state
  gsr_pkg::gsr_poll_state_e next_state;  // Next watcher state
  logic                     hit;         // Response on an unmasked line

  // During the poll phase, a 1 on any line whose mask bit is set counts as a response
  assign hit        = poll_phase_i && ((data_lines_i & mask_i) != 8'h00);
  assign sampling_o = (state == gsr_pkg::GSR_POLL_SAMPLE);
  assign request_o  = (state == gsr_pkg::GSR_POLL_HELD);

  // Next-state choice
  always_comb
  begin
    next_state = state;
    case (state)
      gsr_pkg::GSR_POLL_OFF:
      begin
        if (enable_i)
          next_state = gsr_pkg::GSR_POLL_SAMPLE;
      end
      gsr_pkg::GSR_POLL_SAMPLE:
      begin
        // Response freezes sampling until software acknowledges
        if (enable_i && hit)
          next_state = gsr_pkg::GSR_POLL_HELD;
        else if (!enable_i)
          next_state = gsr_pkg::GSR_POLL_OFF;
      end
      gsr_pkg::GSR_POLL_HELD:
      begin
        // Only an acknowledge releases the request
        if (clear_i)
          next_state = enable_i ? gsr_pkg::GSR_POLL_SAMPLE : gsr_pkg::GSR_POLL_OFF;
      end
      default:
      begin
        next_state = gsr_pkg::GSR_POLL_OFF;
      end
    endcase
  end

  // State flop
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      state <= gsr_pkg::GSR_POLL_OFF;
    else
      state <= next_state;
  end

endmodule

// ==== hdl/gsr_regs.sv ====
// What this block does
// - Registers mirrored throughout the 64 KiB slot
// - Status reads 1, pending, 0, DMA enable
// - Pending flag shows controller level-3 request
// - Bit 0 read/write enables DMA channel 0
// - Status writes touch only DMA enable
// - Undefined status/ext bits float, writes ignored
// - Extended status is read-only
// - Ext bit 7 shows system-controller line
// - Ext bit 6 shows active-low in-charge
// - Ext bit 2 keyboard level-7, bit 0 one
// - Poll status: enable, request; write 0 clears
// - Eight-bit mask selects examined data lines
// - Response raises level 3, stops sampling
module gsr_regs (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // Processor I/O bus
  input  wire logic        io_strobe_i,
  input  wire logic        io_write_i,
  input  wire logic [23:0] io_addr_i,
  input  wire logic [7:0]  io_wdata_i,
  output logic [7:0]       io_rdata_o,
  output logic [7:0]       io_rdata_oe_o,
  output logic             io_ack_o,
  output logic             ctl_chip_sel_o,
  // Controller chip and board status
  input  wire logic        chip_irq_i,
  input  wire logic        sys_controller_line_i,
  input  wire logic        in_charge_n_i,
  input  wire logic        keyboard_level7_irq_i,
  // Parallel poll bus view
  input  wire logic [7:0]  bus_data_i,
  input  wire logic        poll_phase_i,
  // Outputs to the system
  output logic             dma_chan0_enable_o,
  output logic             irq_level3_o
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [gsr_pkg::MIRROR_BITS-1:0] offset;      // Mirrored register index
  logic                            slot_hit;    // Access lands in our slot
  logic                            sel_stat;    // Status/control selected
  logic                            sel_ext;     // Extended status selected
  logic                            sel_poll;    // Poll status selected
  logic                            sel_mask;    // Poll mask selected
  logic                            sel_ours;    // Any support register
  logic                            wr_stat;     // Write to status/control
  logic                            wr_poll;     // Write to poll status
  logic                            wr_mask;     // Write to poll mask
  logic                            rd_any;      // Read of a support register

  // Upper slot bits between select and index are ignored, so images repeat
  assign offset   = io_addr_i[gsr_pkg::MIRROR_BITS-1:0];
  assign slot_hit = io_strobe_i && (io_addr_i[23:16] == gsr_pkg::SLOT_SELECT);
  assign sel_stat = slot_hit && (offset == gsr_pkg::REG_STATUS_CTRL_ADDR[gsr_pkg::MIRROR_BITS-1:0]);
  assign sel_ext  = slot_hit && (offset == gsr_pkg::REG_EXT_STATUS_ADDR[gsr_pkg::MIRROR_BITS-1:0]);
  assign sel_poll = slot_hit && (offset == gsr_pkg::REG_POLL_STATUS_ADDR[gsr_pkg::MIRROR_BITS-1:0]);
  assign sel_mask = slot_hit && (offset == gsr_pkg::REG_POLL_MASK_ADDR[gsr_pkg::MIRROR_BITS-1:0]);
  assign sel_ours = sel_stat || sel_ext || sel_poll || sel_mask;
  // Extended status gets no write strobe, so writes to it change nothing
  assign wr_stat  = sel_stat && io_write_i;
  assign wr_poll  = sel_poll && io_write_i;
  assign wr_mask  = sel_mask && io_write_i;
  assign rd_any   = sel_ours && !io_write_i;

  // Every other image in the slot belongs to the controller chip
  assign ctl_chip_sel_o = slot_hit && !sel_ours;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic       dma_en;          // DMA channel 0 enable
  logic       poll_irq_enable; // Parallel-poll interrupt enable
  logic [7:0] poll_mask;       // Lines examined during poll
  logic       poll_req;        // Request held by the watcher
  logic       poll_clear;      // Acknowledge: write 0 to request bit
  logic       poll_sampling;   // Watcher is looking at the lines

  // Status write keeps only bit 0; the rest is dropped
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      dma_en <= gsr_pkg::DMA_ENABLE_RESET;
    else if (wr_stat)
      dma_en <= io_wdata_i[gsr_pkg::STAT_DMA_BIT];
  end

  // Poll enable; reset leaves polling off until software arms it
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      poll_irq_enable <= gsr_pkg::POLL_ENABLE_RESET;
    else if (wr_poll)
      poll_irq_enable <= io_wdata_i[gsr_pkg::POLL_ENABLE_BIT];
  end

  // Poll mask, plain read/write
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      poll_mask <= gsr_pkg::POLL_MASK_RESET;
    else if (wr_mask)
      poll_mask <= io_wdata_i;
  end

  // Writing a 1 to the request bit does nothing
  assign poll_clear = wr_poll && !io_wdata_i[gsr_pkg::POLL_REQUEST_BIT];

  // ----------------------------------------------------------------
  // Parallel-poll watcher
  // ----------------------------------------------------------------
  // The watcher sets only while sampling and clears only while holding,
  // so a set can never be lost to a clear in the same cycle
  gsr_poll_detect i_gsr_poll_detect (
    .clk_i        (clk_i),
    .nrst_i       (nrst_i),
    .enable_i     (poll_irq_enable),
    .mask_i       (poll_mask),
    .clear_i      (poll_clear),
    .data_lines_i (bus_data_i),
    .poll_phase_i (poll_phase_i),
    .request_o    (poll_req),
    .sampling_o   (poll_sampling)
  );

  // ----------------------------------------------------------------
  // Read data mux
  // ----------------------------------------------------------------
  logic [7:0] stat_word;     // Status image
  logic [7:0] ext_word;      // Extended status image
  logic [7:0] poll_word;     // Poll status image
  logic [7:0] rd_word;       // Selected word
  logic [7:0] rd_oe;         // Selected drive pattern

  // Status image built bit by bit; undefined positions read zero here
  always_comb
  begin
    stat_word                         = 8'h00;
    stat_word[gsr_pkg::STAT_ONE_BIT]  = 1'b1;
    stat_word[gsr_pkg::STAT_PEND_BIT] = chip_irq_i;
    stat_word[gsr_pkg::STAT_ZERO_BIT] = 1'b0;
    stat_word[gsr_pkg::STAT_DMA_BIT]  = dma_en;
  end

  // Board lines pass straight through; pins count as synchronous
  always_comb
  begin
    ext_word                            = 8'h00;
    ext_word[gsr_pkg::EXT_SYSCTL_BIT]   = sys_controller_line_i;
    ext_word[gsr_pkg::EXT_CIC_BIT]      = in_charge_n_i;
    ext_word[gsr_pkg::EXT_KEYBOARD_BIT] = keyboard_level7_irq_i;
    ext_word[gsr_pkg::EXT_ONE_BIT]      = 1'b1;
  end

  // Poll status; the six low bits are driven zeros, not floating
  always_comb
  begin
    poll_word                            = 8'h00;
    poll_word[gsr_pkg::POLL_ENABLE_BIT]  = poll_irq_enable;
    poll_word[gsr_pkg::POLL_REQUEST_BIT] = poll_req;
  end

  // Undefined status and ext positions are left undriven so the bus floats there
  assign rd_word = sel_stat ? stat_word :
                   sel_ext  ? ext_word  :
                   sel_poll ? poll_word : poll_mask;
  assign rd_oe   = sel_stat ? gsr_pkg::STAT_DRIVEN_MASK :
                   sel_ext  ? gsr_pkg::EXT_DRIVEN_MASK  :
                              gsr_pkg::ALL_DRIVEN_MASK;

  // Read data and acknowledge, one cycle after the strobe
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      io_rdata_o    <= 8'h00;
      io_rdata_oe_o <= 8'h00;
      io_ack_o      <= 1'b0;
    end
    else
    begin
      io_rdata_o    <= rd_any ? rd_word : 8'h00;
      io_rdata_oe_o <= rd_any ? rd_oe : 8'h00;
      io_ack_o      <= sel_ours;
    end
  end

  // ----------------------------------------------------------------
  // System outputs
  // ----------------------------------------------------------------
  // DMA and poll share the local bus; software must not enable both
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      dma_chan0_enable_o <= 1'b0;
      irq_level3_o       <= 1'b0;
    end
    else
    begin
      dma_chan0_enable_o <= dma_en;
      irq_level3_o       <= chip_irq_i || (poll_req && poll_irq_enable);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // Helper: first cycle after reset release
  logic first_cycle;
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      first_cycle <= 1'b1;
    else
      first_cycle <= 1'b0;
  end

  a_reset_enables_off: assert property (first_cycle |-> !dma_en && !poll_irq_enable && !dma_chan0_enable_o)
    else $error("Enables not cleared by reset");

  a_mirror_any_image: assert property (
    (io_strobe_i && io_addr_i[23:16] == 8'h47 && io_addr_i[3:0] == 4'h3) |=> io_ack_o)
    else $error("Mirrored status image not answered");

  a_status_read_bits: assert property (
    (sel_stat && !io_write_i) |=> io_rdata_o[7] && !io_rdata_o[2]
      && io_rdata_o[0] == $past(dma_en) && io_rdata_oe_o == 8'hC5)
    else $error("Status read image wrong");

  a_pending_follows: assert property (
    (sel_stat && !io_write_i) |=> io_rdata_o[6] == $past(chip_irq_i))
    else $error("Pending flag does not follow controller irq");

  a_dma_write_out: assert property (
    wr_stat |-> ##2 dma_chan0_enable_o == $past(io_wdata_i[0], 2))
    else $error("DMA enable not written");

  a_status_write_only: assert property (
    (wr_stat && !wr_poll && !wr_mask) |=> $stable(poll_irq_enable) && $stable(poll_mask))
    else $error("Status write touched other state");

  a_ext_float_bits: assert property (
    (sel_ext && !io_write_i) |=> io_rdata_oe_o[5:3] == 3'b000 && io_rdata_oe_o[1] == 1'b0)
    else $error("Undefined ext bits driven");

  a_ext_write_none: assert property (
    (sel_ext && io_write_i) |=> $stable(dma_en) && $stable(poll_irq_enable) && $stable(poll_mask))
    else $error("Write to ext status changed state");

  a_ext_read_lines: assert property (
    (sel_ext && !io_write_i) |=> io_rdata_o[7] == $past(sys_controller_line_i)
      && io_rdata_o[6] == $past(in_charge_n_i) && io_rdata_o[2] == $past(keyboard_level7_irq_i)
      && io_rdata_o[0])
    else $error("Ext status image wrong");

  a_ack_clears_req: assert property (
    (poll_req && poll_clear) |=> !poll_req)
    else $error("Acknowledge did not clear request");

  a_mask_blocks_hit: assert property (
    (poll_sampling && ((bus_data_i & poll_mask) == 8'h00)) |=> !poll_req)
    else $error("Masked line raised request");

  a_hit_raises_irq: assert property (
    (poll_sampling && poll_irq_enable && poll_phase_i && ((bus_data_i & poll_mask) != 8'h00))
      |=> poll_req ##1 irq_level3_o)
    else $error("Poll response did not raise level 3");

  a_held_no_sample: assert property (
    (poll_req && !poll_clear) |=> poll_req && !poll_sampling)
    else $error("Request lost or sampling resumed");

  a_chip_raises_irq: assert property (
    chip_irq_i |=> irq_level3_o)
    else $error("Controller request did not reach level 3");

  a_dma_held_still: assert property (
    !wr_stat |=> $stable(dma_en))
    else $error("DMA enable changed without a status write");

  a_mask_write_lands: assert property (
    wr_mask |=> poll_mask == $past(io_wdata_i))
    else $error("Poll mask write lost");

  a_poll_off_quiet: assert property (
    (!poll_irq_enable && !poll_req) |=> !poll_req)
    else $error("Disabled watcher raised a request");

  a_chip_no_ack: assert property (
    ctl_chip_sel_o |=> !io_ack_o)
    else $error("Controller chip image answered by support registers");

  c_poll_interrupt: cover property (poll_sampling ##1 poll_req ##[1:20] poll_clear);
  c_dma_enabled: cover property (wr_stat && io_wdata_i[0]);
  c_ext_read: cover property (sel_ext && !io_write_i);
  c_chip_access: cover property (ctl_chip_sel_o);
  c_mask_written: cover property (wr_mask);

endmodule

// ==== test/gsr_host_model.sv ====
module gsr_host_model (
  // Clock
  input  wire logic        clk_i,
  // Requests towards the support registers
  output logic             strobe_o,
  output logic             write_o,
  output logic [23:0]      addr_o,
  output logic [7:0]       wdata_o,
  // Answers from the support registers
  input  wire logic [7:0]  rdata_i,
  input  wire logic [7:0]  rdata_oe_i,
  input  wire logic        ack_i,
  input  wire logic        chip_sel_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Idle bus
  // ----------------------------------------------------------------
  initial
  begin
    strobe_o = 1'b0;
    write_o  = 1'b0;
    addr_o   = 24'h00_0000;
    wdata_o  = 8'h00;
  end

  // ----------------------------------------------------------------
  // One access
  // ----------------------------------------------------------------
  // Strobe stands one cycle only: a longer strobe would be a second access
  task automatic access(input logic wr, input logic [23:0] addr, input logic [7:0] data,
                        output logic [7:0] rd, output logic [7:0] oe, output logic ak, output logic sel);
    @(posedge clk_i);
    #1;
    strobe_o = 1'b1;
    write_o  = wr;
    addr_o   = addr;
    wdata_o  = data;
    // Chip select is combinational, so look inside the strobe cycle
    #1;
    sel = chip_sel_i;
    @(posedge clk_i);
    #1;
    // Answer stands just after the taking edge, registered there from the strobe
    rd = rdata_i;
    oe = rdata_oe_i;
    ak = ack_i;
    // Released lines show the inverse, never a stale copy
    strobe_o = 1'b0;
    write_o  = ~wr;
    addr_o   = ~addr;
    wdata_o  = ~data;
  endtask
endmodule

// ==== test/test_gpib_support_regs.sv ====
module test_gpib_support_regs;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Signals and addresses
  // ----------------------------------------------------------------
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        io_strobe_i, io_write_i;
  logic [23:0] io_addr_i;
  logic [7:0]  io_wdata_i, io_rdata_o, io_rdata_oe_o;
  logic        io_ack_o, ctl_chip_sel_o;
  logic        chip_irq_i = 1'b0, sys_controller_line_i = 1'b0;
  logic        in_charge_n_i = 1'b1, keyboard_level7_irq_i = 1'b0;
  logic [7:0]  bus_data_i = 8'h00;
  logic        poll_phase_i = 1'b0;
  logic        dma_chan0_enable_o, irq_level3_o;
  int          err_total = 0;
  int          n_tests = 0;
  localparam logic [23:0] A_ST = gsr_pkg::REG_STATUS_CTRL_ADDR;
  localparam logic [23:0] A_EX = gsr_pkg::REG_EXT_STATUS_ADDR;
  localparam logic [23:0] A_PS = gsr_pkg::REG_POLL_STATUS_ADDR;
  localparam logic [23:0] A_PM = gsr_pkg::REG_POLL_MASK_ADDR;

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  gsr_regs i_gsr_regs (.clk_i(clk_i), .nrst_i(nrst_i), .io_strobe_i(io_strobe_i), .io_write_i(io_write_i),
    .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .io_rdata_oe_o(io_rdata_oe_o),
    .io_ack_o(io_ack_o), .ctl_chip_sel_o(ctl_chip_sel_o), .chip_irq_i(chip_irq_i),
    .sys_controller_line_i(sys_controller_line_i), .in_charge_n_i(in_charge_n_i),
    .keyboard_level7_irq_i(keyboard_level7_irq_i), .bus_data_i(bus_data_i), .poll_phase_i(poll_phase_i),
    .dma_chan0_enable_o(dma_chan0_enable_o), .irq_level3_o(irq_level3_o));

  gsr_host_model i_gsr_host_model (.clk_i(clk_i), .strobe_o(io_strobe_i), .write_o(io_write_i),
    .addr_o(io_addr_i), .wdata_o(io_wdata_i), .rdata_i(io_rdata_o), .rdata_oe_i(io_rdata_oe_o),
    .ack_i(io_ack_o), .chip_sel_i(ctl_chip_sel_o));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      err_total++;
    end
  endtask

  // Lands just after an edge so every update has settled
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Read one register; only driven bits are compared as data
  task automatic rd(input logic [23:0] a, input logic [7:0] exp, input logic [7:0] exp_oe);
    logic [7:0] d, o;
    logic       k, s;
    i_gsr_host_model.access(1'b0, a, 8'h00, d, o, k, s);
    chk("read ack", 8'h01, {7'h00, k});
    chk("read enables", exp_oe, o);
    chk("read data", exp, d & exp_oe);
  endtask

  task automatic wr(input logic [23:0] a, input logic [7:0] data);
    logic [7:0] d, o;
    logic       k, s;
    i_gsr_host_model.access(1'b1, a, data, d, o, k, s);
    chk("write ack", 8'h01, {7'h00, k});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_values;
    rd(A_ST, 8'h80, 8'hC5);
    chk("dma enable", 8'h00, {7'h00, dma_chan0_enable_o});
    rd(A_PS, 8'h00, 8'hFF);
    rd(A_PM, 8'h00, 8'hFF);
  endtask

  task automatic test_status_ctrl;
    logic [7:0] d, o;
    logic       k, s;
    // Everything but the enable bit set, through a far mirror
    wr(24'h47_FFF3, 8'hFE);
    rd(A_ST, 8'h80, 8'hC5);
    wr(24'h47_0013, 8'h01);
    step(1);
    chk("dma enable", 8'h01, {7'h00, dma_chan0_enable_o});
    rd(24'h47_ABC3, 8'h81, 8'hC5);
    chip_irq_i = 1'b1;
    step(2);
    chk("level 3 irq", 8'h01, {7'h00, irq_level3_o});
    rd(A_ST, 8'hC1, 8'hC5);
    chip_irq_i = 1'b0;
    wr(A_ST, 8'h00);
    step(1);
    chk("dma enable", 8'h00, {7'h00, dma_chan0_enable_o});
    // Slot hit on the controller chip itself, then a miss outside the slot
    i_gsr_host_model.access(1'b0, 24'h47_0001, 8'h00, d, o, k, s);
    chk("chip ack", 8'h00, {7'h00, k});
    chk("chip select", 8'h01, {7'h00, s});
    i_gsr_host_model.access(1'b0, 24'h48_0003, 8'h00, d, o, k, s);
    chk("miss ack", 8'h00, {7'h00, k});
    chk("miss select", 8'h00, {7'h00, s});
  endtask

  task automatic test_ext_status;
    for (int i = 0; i < 8; i++)
    begin
      sys_controller_line_i = i[2];
      in_charge_n_i         = i[1];
      keyboard_level7_irq_i = i[0];
      rd(A_EX, {i[2], i[1], 3'h0, i[0], 2'h1}, 8'hC5);
    end
    // All three lines high now; a write must change nothing
    wr(A_EX, 8'h00);
    rd(A_EX, 8'hC5, 8'hC5);
  endtask

  task automatic test_poll;
    wr(A_PM, 8'h04);
    rd(A_PM, 8'h04, 8'hFF);
    wr(A_PS, 8'h80);
    step(2);
    // Responses only on masked-off lines must be ignored
    poll_phase_i = 1'b1;
    bus_data_i   = 8'hFB;
    step(6);
    chk("level 3 irq", 8'h00, {7'h00, irq_level3_o});
    bus_data_i = 8'h04;
    for (int k = 0; k < 8 && irq_level3_o !== 1'b1; k++)
      step(1);
    chk("level 3 irq", 8'h01, {7'h00, irq_level3_o});
    if (irq_level3_o !== 1'b1)
      results();
    rd(A_PS, 8'hC0, 8'hFF);
    // Writing a one to the request flag leaves it set
    wr(A_PS, 8'hC0);
    rd(A_PS, 8'hC0, 8'hFF);
    poll_phase_i = 1'b0;
    wr(A_PS, 8'h80);
    rd(A_PS, 8'h80, 8'hFF);
    chk("level 3 irq", 8'h00, {7'h00, irq_level3_o});
    // Disabled watcher ignores a response
    wr(A_PS, 8'h00);
    poll_phase_i = 1'b1;
    bus_data_i   = 8'hFF;
    step(6);
    chk("level 3 irq", 8'h00, {7'h00, irq_level3_o});
    rd(A_PS, 8'h00, 8'hFF);
    poll_phase_i = 1'b0;
    bus_data_i   = 8'h00;
  endtask

  task automatic test_mid_reset;
    wr(A_ST, 8'h01);
    wr(A_PS, 8'h80);
    nrst_i = 1'b0;
    step(2);
    nrst_i = 1'b1;
    step(1);
    chk("dma enable", 8'h00, {7'h00, dma_chan0_enable_o});
    rd(A_PS, 8'h00, 8'hFF);
    rd(A_ST, 8'h80, 8'hC5);
  endtask

  // ----------------------------------------------------------------
  // Verdict and main sequence
  // ----------------------------------------------------------------
  task automatic results;
    if (err_total == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge clk_i);
    #1;
    nrst_i = 1'b1;
    test_reset_values();
    test_status_ctrl();
    test_ext_status();
    test_poll();
    test_mid_reset();
    results();
  end
endmodule
